// >>> hw/bsd_boot_strap_decoder.v
// Boot strap capture, decode and boot source sequencer
`timescale 1ns/1ps
`include "bsd_boot_regs.vh"
module bsd_boot_strap_decoder #(
    parameter [3:0] SETTLE_COUNT = `BSD_SETTLE_CYCLES
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [15:0] bootStrapPins,
    input wire sourceDone,
    input wire sourceFail,
    output reg [1:0] xtalSelect,
    output reg auxClockOutputOneEn,
    output reg strapReserved,
    output reg [4:0] bootCode,
    output reg configValid,
    output reg [2:0] activeSource,
    output reg sourceStart,
    output reg bootSuccess,
    output reg bootExhausted
);
    // ****************************************
    // Sequencer states
    // ****************************************
    localparam ST_SETTLE = 3'h0;
    localparam ST_CAPTURE = 3'h1;
    localparam ST_START = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_BOOTED = 3'h4;
    localparam ST_FAILED = 3'h5;

    // ****************************************
    // Internal registers and nets
    // ****************************************
    reg [15:0] pinSync1Reg;
    reg [15:0] pinSync2Reg;
    reg [15:0] strapLatchReg;
    reg [2:0] stateReg;
    reg [2:0] stateNext;
    reg [3:0] settleReg;
    reg [1:0] stepReg;
    reg [1:0] stepNext;
    wire [2:0] tableSource;
    wire tableValid;
    wire [1:0] latchXtal;
    wire latchReserved;
    wire latchAuxClock;
    wire [4:0] latchCode;
    wire settleDone;
    wire captureNow;
    wire launchSource;
    wire imageFound;
    wire imageMissing;
    wire enterFailed;

    // ****************************************
    // Strap pin synchroniser
    // ****************************************
    // Runs through reset so the latch below sees settled pins
    always @(posedge sys_clk) begin
        pinSync1Reg <= bootStrapPins;
        pinSync2Reg <= pinSync1Reg;
    end

    // ****************************************
    // Strap latch
    // ****************************************
    // Follows the pins while board reset is low and freezes at release,
    // so header overrides may drop away as soon as reset ends
    always @(posedge sys_clk) begin
        if (!rst_n) begin // R1
            strapLatchReg <= pinSync2Reg;
        end
    end

    // ****************************************
    // Strap field split
    // ****************************************
    assign latchXtal = strapLatchReg[`BSD_XTAL_HI:`BSD_XTAL_LO]; // R2
    assign latchReserved = |strapLatchReg[`BSD_RSVD_HI:`BSD_RSVD_LO];
    assign latchAuxClock = strapLatchReg[`BSD_AUXCLK_BIT]; // R5
    // Bits 11 to 6 are left unread
    assign latchCode = strapLatchReg[`BSD_CODE_HI:`BSD_CODE_LO]; // R4

    // ****************************************
    // Boot order table
    // ****************************************
    bsd_source_table uTable (
        .bootCode(bootCode),
        .stepIndex(stepReg),
        .sourceId(tableSource),
        .codeValid(tableValid)
    );

    // ****************************************
    // Sequencer events
    // ****************************************
    assign settleDone = (settleReg == SETTLE_COUNT);
    assign captureNow = (stateReg == ST_CAPTURE);
    assign launchSource = (stateReg == ST_START) && tableValid;
    assign imageFound = (stateReg == ST_WAIT) && sourceDone;
    // Done wins when both answers arrive together
    assign imageMissing = (stateReg == ST_WAIT) && !sourceDone && sourceFail; // R8
    assign enterFailed = (stateNext == ST_FAILED) && (stateReg != ST_FAILED);

    // ****************************************
    // Next state
    // ****************************************
    always @* begin
        stateNext = stateReg;
        stepNext = stepReg;
        case (stateReg)
            ST_SETTLE: begin
                if (settleDone) begin
                    stateNext = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                stateNext = ST_START;
            end
            ST_START: begin
                if (tableValid) begin
                    stateNext = ST_WAIT;
                end else begin
                    stateNext = ST_FAILED;
                end
            end
            ST_WAIT: begin
                if (imageFound) begin
                    stateNext = ST_BOOTED;
                end else if (imageMissing) begin // R8
                    if (stepReg == 2'h3) begin
                        stateNext = ST_FAILED;
                    end else begin
                        stepNext = stepReg + 2'h1;
                        stateNext = ST_START;
                    end
                end
            end
            ST_BOOTED: begin
                stateNext = ST_BOOTED;
            end
            ST_FAILED: begin
                stateNext = ST_FAILED;
            end
            default: begin
                stateNext = ST_SETTLE;
            end
        endcase
    end

    // ****************************************
    // State, step and settle registers
    // ****************************************
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            stateReg <= ST_SETTLE;
            stepReg <= 2'h0;
        end else begin
            stateReg <= stateNext;
            stepReg <= stepNext;
        end
    end

    // Settle counter stops once the sequencer leaves the settle state
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            settleReg <= 4'h0;
        end else if (stateReg == ST_SETTLE) begin
            settleReg <= settleReg + 4'h1;
        end
    end

    // ****************************************
    // Configuration capture
    // ****************************************
    // Loaded once per reset from the frozen latch; later pin activity is ignored
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            xtalSelect <= 2'h0;
            auxClockOutputOneEn <= 1'b0;
            strapReserved <= 1'b0;
            bootCode <= 5'h00;
            configValid <= 1'b0;
        end else if (captureNow) begin // R1 R11
            xtalSelect <= latchXtal; // R2
            strapReserved <= latchReserved;
            auxClockOutputOneEn <= latchAuxClock; // R5
            bootCode <= latchCode; // R4
            configValid <= 1'b1;
        end
    end

    // ****************************************
    // Source launch
    // ****************************************
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            activeSource <= `BSD_SRC_NONE;
            sourceStart <= 1'b0;
        end else begin
            sourceStart <= launchSource;
            if (enterFailed) begin // R8
                activeSource <= `BSD_SRC_NONE;
            end else if (launchSource) begin // R6 R7
                activeSource <= tableSource;
            end
        end
    end

    // ****************************************
    // Outcome flags
    // ****************************************
    // Both flags are sticky until the next board reset
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            bootSuccess <= 1'b0;
        end else if (imageFound) begin // R8
            bootSuccess <= 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            bootExhausted <= 1'b0;
        end else if (enterFailed) begin // R8
            bootExhausted <= 1'b1;
        end
    end
endmodule // bsd_boot_strap_decoder

// >>> hw/bsd_source_table.v
// Boot source lookup: boot code and step index to source id
`timescale 1ns/1ps
`include "bsd_boot_regs.vh"
module bsd_source_table (
    input wire [4:0] bootCode,
    input wire [1:0] stepIndex,
    output reg [2:0] sourceId,
    output reg codeValid
);
    always @* begin
        sourceId = `BSD_SRC_NONE;
        codeValid = 1'b0;
        case (bootCode)
            `BSD_CODE_DEFAULT: begin
                codeValid = 1'b1;
                case (stepIndex) // R6
                    2'h0: sourceId = `BSD_SRC_ONBOARD_FLASH_CARD;
                    2'h1: sourceId = `BSD_SRC_REMOVABLE_CARD;
                    2'h2: sourceId = `BSD_SRC_CONSOLE_SERIAL;
                    default: sourceId = `BSD_SRC_USB_DEVICE;
                endcase
            end
            `BSD_CODE_ALT: begin
                codeValid = 1'b1;
                case (stepIndex) // R7
                    2'h0: sourceId = `BSD_SRC_SERIAL_FLASH;
                    2'h1: sourceId = `BSD_SRC_REMOVABLE_CARD;
                    2'h2: sourceId = `BSD_SRC_USB_DEVICE;
                    default: sourceId = `BSD_SRC_CONSOLE_SERIAL;
                endcase
            end
            default: begin
                sourceId = `BSD_SRC_NONE;
                codeValid = 1'b0;
            end
        endcase
    end
endmodule // bsd_source_table

// >>> pkg/bsd_boot_regs.vh
// Constants for the boot strap decoder
// ****************************************
// Overview of operation
// [R1] Sample the strap pins at power-up; the captured value picks the boot order.
// [R2] Top two strap bits give crystal frequency: 19.2, 24, 25, 26 MHz.
// [R3] Board must drive strap bits 13:12 as 00b; other values reserved.
// [R4] Strap bits 11 through 6 are ignored and never affect boot order.
// [R5] Strap bit 5: 0 keeps aux clock output off, 1 enables it.
// [R6] Code 11100b: onboard flash card, removable card, console serial, USB device.
// [R7] Code 11000b: serial flash, removable card, USB device, console serial.
// [R8] A source with no usable image makes the device try the next one.
// [R9] Holding the boot select switch pulls one strap bit low for the alternate order.
// [R10] External overrides should be gated by board reset and released after it.
// [R11] Captured strap value stays fixed after reset until the next reset.
// ****************************************
`ifndef BSD_BOOT_REGS_VH
`define BSD_BOOT_REGS_VH
`define BSD_STRAP_WIDTH 16
`define BSD_XTAL_HI 15
`define BSD_XTAL_LO 14
`define BSD_RSVD_HI 13
`define BSD_RSVD_LO 12
`define BSD_AUXCLK_BIT 5
`define BSD_CODE_HI 4
`define BSD_CODE_LO 0
`define BSD_CODE_DEFAULT 5'h1C
`define BSD_CODE_ALT 5'h18
`define BSD_XTAL_19M2 2'h0
`define BSD_XTAL_24M 2'h1
`define BSD_XTAL_25M 2'h2
`define BSD_XTAL_26M 2'h3
`define BSD_SRC_NONE 3'h0
`define BSD_SRC_ONBOARD_FLASH_CARD 3'h1
`define BSD_SRC_REMOVABLE_CARD 3'h2
`define BSD_SRC_CONSOLE_SERIAL 3'h3
`define BSD_SRC_USB_DEVICE 3'h4
`define BSD_SRC_SERIAL_FLASH 3'h5
`define BSD_SEQ_LEN 4
`define BSD_SETTLE_CYCLES 4'h4
`endif

// >>> testbench/boot_strap_decoder_tb.sv
// Testbench for the boot strap decoder
`timescale 1ns/1ps
module boot_strap_decoder_tb;
    logic sys_clk = 0, rst_n = 0, sourceDone = 0, sourceFail = 0, swHeld = 0, ovEn = 0;
    logic [15:0] ovVal = 0, noise = 0, pins;
    wire [1:0] xtalSelect;
    wire [4:0] bootCode;
    wire [2:0] activeSource;
    wire auxClockOutputOneEn, strapReserved, configValid, sourceStart, bootSuccess, bootExhausted;
    int n_errors = 0, total_checks = 0;
    always #25 sys_clk = ~sys_clk;
    bsd_board_model board (.rst_n(rst_n), .switchHeld(swHeld), .overrideEn(ovEn), .overrideVal(ovVal),
        .lateNoise(noise), .bootStrapPins(pins));
    bsd_boot_strap_decoder dut (.sys_clk(sys_clk), .rst_n(rst_n), .bootStrapPins(pins), .sourceDone(sourceDone),
        .sourceFail(sourceFail), .xtalSelect(xtalSelect), .auxClockOutputOneEn(auxClockOutputOneEn),
        .strapReserved(strapReserved), .bootCode(bootCode), .configValid(configValid), .activeSource(activeSource),
        .sourceStart(sourceStart), .bootSuccess(bootSuccess), .bootExhausted(bootExhausted));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task step;
        @(posedge sys_clk);
        #1;
    endtask
    task boot(input logic [15:0] ov, input logic sw);
        ovVal = ov;
        ovEn = 1;
        swHeld = sw;
        noise = 0;
        rst_n = 0;
        repeat (6) step;
        rst_n = 1;
        for (int i = 0; i < 20 && configValid !== 1; i++) step;
        check(configValid, 1'b1);
    endtask
    task src(input logic [2:0] exp, input logic done);
        for (int i = 0; i < 10 && sourceStart !== 1; i++) step;
        check(sourceStart, 1'b1);
        check(activeSource, exp);
        step;
        sourceDone = done;
        sourceFail = !done;
        step;
        sourceDone = 0;
        sourceFail = 0;
    endtask
    task t_default;
        boot(16'h803c, 0);
        check({xtalSelect, auxClockOutputOneEn, strapReserved, bootCode}, {2'h2, 1'h1, 1'h0, 5'h1c});
        src(3'h1, 0);
        src(3'h2, 0);
        src(3'h3, 0);
        src(3'h4, 0);
        step;
        check({bootSuccess, bootExhausted, activeSource}, 5'h08);
    endtask
    task t_alt;
        boot(16'hcfdc, 1);
        check({xtalSelect, auxClockOutputOneEn, bootCode}, {2'h3, 1'h0, 5'h18});
        src(3'h5, 0);
        src(3'h2, 0);
        src(3'h4, 1);
        check({bootSuccess, bootExhausted}, 2'h2);
        noise = 16'hffff;
        repeat (4) step;
        check({xtalSelect, bootCode, bootSuccess}, {2'h3, 5'h18, 1'h1});
    endtask
    task t_unknown;
        for (int x = 0; x < 2; x++) begin
            boot({x[1:0], 14'h0}, 0);
            repeat (2) step;
            check({xtalSelect, bootExhausted, sourceStart}, {x[1:0], 2'h2});
        end
    endtask
    task summarize;
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        summarize;
    end
    initial begin
        t_default;
        t_alt;
        t_unknown;
        summarize;
    end
endmodule // boot_strap_decoder_tb

// >>> testbench/bsd_board_model.sv
// Board straps, boot select switch and header override
`timescale 1ns/1ps
module bsd_board_model #(parameter logic [15:0] STRAP_DEFAULT = 16'h403c) (
    input wire logic rst_n,
    input wire logic switchHeld,
    input wire logic overrideEn,
    input wire logic [15:0] overrideVal,
    input wire logic [15:0] lateNoise,
    output logic [15:0] bootStrapPins
);
    // Header override drives only while board reset is low, then the resistors return
    assign bootStrapPins = ((overrideEn && !rst_n) ? overrideVal : STRAP_DEFAULT)
        & ~{13'h0, switchHeld, 2'h0} ^ lateNoise;
endmodule // bsd_board_model

// >>> testbench/bsd_boot_strap_decoder_properties.sv
// Checker for the boot strap decoder ports
`timescale 1ns/1ps
module bsd_boot_strap_decoder_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [15:0] bootStrapPins,
    input wire logic sourceDone,
    input wire logic sourceFail,
    input wire logic [1:0] xtalSelect,
    input wire logic auxClockOutputOneEn,
    input wire logic strapReserved,
    input wire logic [4:0] bootCode,
    input wire logic configValid,
    input wire logic [2:0] activeSource,
    input wire logic sourceStart,
    input wire logic bootSuccess,
    input wire logic bootExhausted
);
    logic [15:0] resetPins0Reg;
    logic [15:0] resetPins1Reg;
    logic [15:0] resetPins2Reg;
    // Pins seen over the last three edges of reset
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            resetPins0Reg <= bootStrapPins;
            resetPins1Reg <= resetPins0Reg;
            resetPins2Reg <= resetPins1Reg;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    cfg_hold_a: assert property (configValid && $past(configValid) |->
        $stable({xtalSelect, auxClockOutputOneEn, strapReserved, bootCode})) else $error("config moved");
    cfg_decode_a: assert property ($rose(configValid) && resetPins0Reg == resetPins2Reg |->
        {xtalSelect, auxClockOutputOneEn, strapReserved, bootCode} ==
        {resetPins0Reg[15:14], resetPins0Reg[5], |resetPins0Reg[13:12], resetPins0Reg[4:0]}) else $error("bad decode");
    first_dflt_a: assert property ($rose(configValid) && bootCode == 5'h1c |=>
        sourceStart && activeSource == 3'h1) else $error("bad first source");
    first_alt_a: assert property ($rose(configValid) && bootCode == 5'h18 |=>
        sourceStart && activeSource == 3'h5) else $error("bad first source");
    fail_next_a: assert property (sourceStart ##1 (sourceFail && !sourceDone) |=>
        ##[0:1] (sourceStart || bootExhausted)) else $error("no next source");
    done_ok_a: assert property (sourceStart ##1 sourceDone |=> bootSuccess) else $error("no success");
    bad_code_a: assert property ($rose(configValid) && bootCode != 5'h1c && bootCode != 5'h18 |=>
        ##[0:1] bootExhausted) else $error("no exhaust");
    start_pulse_a: assert property (sourceStart |=> !sourceStart) else $error("start too long");
    exh_idle_a: assert property (bootExhausted |-> activeSource == 3'h0 && !sourceStart) else $error("busy");
endmodule // bsd_boot_strap_decoder_properties
bind bsd_boot_strap_decoder bsd_boot_strap_decoder_properties chk (.sys_clk, .rst_n, .bootStrapPins, .sourceDone,
    .sourceFail, .xtalSelect, .auxClockOutputOneEn, .strapReserved, .bootCode, .configValid, .activeSource,
    .sourceStart, .bootSuccess, .bootExhausted);
